// *** include/rsmc_consts.vh ***
// Constants for the reset and supply monitor controller
`ifndef RSMC_CONSTS_VH
`define RSMC_CONSTS_VH
// Monitor control keeps its word index; the bus sees four times it
`define RSMC_IDX_MON_CTRL 10'h0FF
`define RSMC_ADDR_MON_CTRL {`RSMC_IDX_MON_CTRL, 2'b00}
`define RSMC_ADDR_RST_SRC 12'h004
`define RSMC_ADDR_STATUS 12'h008
`define RSMC_ADDR_FLASH 12'h00C
`define RSMC_BIT_MON_EN 7
`define RSMC_BIT_SUPPLY_OK 6
`define RSMC_BIT_WARN_OK 5
`define RSMC_BIT_WARN_IE 0
`define RSMC_BIT_SW_RST 4
`define RSMC_BIT_POR_FLAG 1
`define RSMC_BIT_FLASH_ERR 6
`define RSMC_BIT_IN_RESET 0
`define RSMC_BIT_FLASH_OP 0
`define RSMC_PORT_RESET 8'hFF
`define RSMC_PC_RESET 16'h0000
`define RSMC_WDT_DIV 4'hC
`define RSMC_WDT_CNT_W 4
`define RSMC_CLK_KHZ 100000
`define RSMC_POR_DELAY_MS 3
// Three milliseconds of the 100 MHz clock, at counter width
`define RSMC_POR_DELAY_CYC 24'h04_93E0
`define RSMC_STRETCH_CYC 24'h00_0008
`define RSMC_CNT_W 24
`define RSMC_RST_IDLE 2'b00
`define RSMC_RST_POR 2'b01
`define RSMC_RST_HOLD 2'b10
`define RSMC_RST_RUN 2'b11
`endif

// *** core/rsmc_wdt_div.v ***
// Watchdog clock divider: one-cycle enable every twelfth system clock
`timescale 1ns/10ps
`include "rsmc_consts.vh"
module rsmc_wdt_div (
    input wire pclk,
    input wire presetn,
    input wire clear,
    output reg tick
);
    reg [`RSMC_WDT_CNT_W-1:0] cnt_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {`RSMC_WDT_CNT_W{1'b0}};
            tick <= 1'b0;
        end else if (clear) begin
            cnt_r <= {`RSMC_WDT_CNT_W{1'b0}};
            tick <= 1'b0;
        end else if (cnt_r == `RSMC_WDT_DIV - 1'b1) begin
            cnt_r <= {`RSMC_WDT_CNT_W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // rsmc_wdt_div

// *** core/rsmc_top.v ***
// Reset sequencer with power-on and supply monitor reset, APB registers
//
// Behaviour
// - Reset halts core, loads registers, disables interrupts
// - Data memory kept; stack pointer reset
// - Port latches all ones, open drain, pullups
// - Reset pin driven low for monitor/power-on
// - Exit: pc zero, internal oscillator, fetch zero
// - Watchdog enabled, clocked system clock div twelve
// - Hold until above power-on threshold, then delay
// - Power-on end sets power-on flag
// - Software and flash resets clear the power-on flag
// - Monitor enabled, selected after power-on/power-fail
// - Supply below threshold holds reset while low
// - Power-fail sets flag; memory marked invalid
// - Monitor state reset only by those resets
// - Sleep suppresses power-fail; wake restores settings
// - Warning flag clears below threshold, may interrupt
// - Flash op with monitor off causes reset
// - No power-on delay after monitor reset
// - Monitor enable bit seven, one after power-on
// - Warning flag bit five, one above threshold
`timescale 1ns/10ps
`include "rsmc_consts.vh"
module rsmc_top #(
    parameter [`RSMC_CNT_W-1:0] POR_DELAY_CYC =
        `RSMC_POR_DELAY_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire power_on_ok,
    input wire supply_above_reset,
    input wire supply_above_warn,
    input wire sleep_mode,
    input wire flash_write_req,
    output reg core_reset_r,
    output reg reset_pin_out_r,
    output reg reset_pin_oe_r,
    output reg [7:0] port_latch_r,
    output reg port_open_drain_r,
    output reg port_pullup_en_r,
    output reg sp_reset_r,
    output reg sfr_init_r,
    output reg irq_timer_disable_r,
    output reg [15:0] pc_r,
    output reg internal_osc_sel_r,
    output reg wdt_enable_r,
    output wire wdt_tick,
    output reg ram_invalid_r,
    output reg warn_irq_r
);
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`RSMC_CNT_W-1:0] cnt_r;
    reg supply_monitor_enable;
    reg monitor_select_r;
    reg power_on_reset_flag;
    reg warn_ie_r;
    reg flash_err_flag_r;
    reg sw_rst_req_r;
    reg flash_rst_req_r;
    reg last_por_r;
    reg [31:0] rdata_r;
    wire supply_early_warning_flag;
    wire mon_live;
    wire pf_fault;
    wire soft_cause;
    wire wr_en;
    wire rd_en;

    function addr_hit;
        input [11:0] a;
        input [11:0] ref_addr;
        begin
            addr_hit = (a == ref_addr);
        end
    endfunction

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = rdata_r;
    assign supply_early_warning_flag = supply_above_warn;
    // Sleep masks the fault; stored settings stay and reapply on wake
    assign mon_live = supply_monitor_enable & monitor_select_r
        & ~sleep_mode;
    assign pf_fault = mon_live & ~supply_above_reset;
    assign soft_cause = sw_rst_req_r | flash_rst_req_r;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            `RSMC_RST_IDLE: begin
                if (power_on_ok)
                    state_nxt = `RSMC_RST_POR;
            end
            `RSMC_RST_POR: begin
                if (!power_on_ok)
                    state_nxt = `RSMC_RST_IDLE;
                else if (cnt_r >= POR_DELAY_CYC - 1'b1)
                    state_nxt = `RSMC_RST_RUN;
            end
            `RSMC_RST_HOLD: begin
                // Losing power mid-stretch restarts the full power-on path
                if (!power_on_ok)
                    state_nxt = `RSMC_RST_IDLE;
                // Monitor release skips the power-on delay
                else if (!pf_fault && cnt_r >= `RSMC_STRETCH_CYC - 1'b1)
                    state_nxt = `RSMC_RST_RUN;
            end
            `RSMC_RST_RUN: begin
                if (!power_on_ok)
                    state_nxt = `RSMC_RST_IDLE;
                else if (pf_fault || soft_cause)
                    state_nxt = `RSMC_RST_HOLD;
            end
            default: state_nxt = `RSMC_RST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= `RSMC_RST_IDLE;
            cnt_r <= {`RSMC_CNT_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r)
                cnt_r <= {`RSMC_CNT_W{1'b0}};
            else if (state_r == `RSMC_RST_POR ||
                     state_r == `RSMC_RST_HOLD)
                cnt_r <= cnt_r + 1'b1;
        end
    end

    // Reset-state effects on the core and pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_r <= 1'b1;
            reset_pin_out_r <= 1'b0;
            reset_pin_oe_r <= 1'b1;
            port_latch_r <= `RSMC_PORT_RESET;
            port_open_drain_r <= 1'b1;
            port_pullup_en_r <= 1'b1;
            sp_reset_r <= 1'b1;
            sfr_init_r <= 1'b1;
            irq_timer_disable_r <= 1'b1;
            pc_r <= `RSMC_PC_RESET;
            internal_osc_sel_r <= 1'b1;
            wdt_enable_r <= 1'b0;
            last_por_r <= 1'b1;
        end else begin
            port_pullup_en_r <= 1'b1;
            if (state_nxt != `RSMC_RST_RUN) begin
                core_reset_r <= 1'b1;
                sfr_init_r <= 1'b1;
                irq_timer_disable_r <= 1'b1;
                sp_reset_r <= 1'b1;
                port_latch_r <= `RSMC_PORT_RESET;
                port_open_drain_r <= 1'b1;
                pc_r <= `RSMC_PC_RESET;
                internal_osc_sel_r <= 1'b1;
                wdt_enable_r <= 1'b0;
                // Pin only for power-on and monitor causes
                reset_pin_oe_r <= (state_nxt != `RSMC_RST_HOLD)
                    | pf_fault | ~soft_cause & last_por_r;
                reset_pin_out_r <= 1'b0;
            end else begin
                core_reset_r <= 1'b0;
                sfr_init_r <= 1'b0;
                irq_timer_disable_r <= 1'b0;
                sp_reset_r <= 1'b0;
                reset_pin_oe_r <= 1'b0;
                reset_pin_out_r <= 1'b1;
                if (core_reset_r)
                    wdt_enable_r <= 1'b1;
            end
            if (state_r == `RSMC_RST_RUN && state_nxt == `RSMC_RST_HOLD)
                last_por_r <= pf_fault;
            else if (state_nxt == `RSMC_RST_IDLE)
                last_por_r <= 1'b1;
        end
    end

    // Divider restarts with every reset so the watchdog starts aligned
    rsmc_wdt_div u_wdt_div (
        .pclk(pclk),
        .presetn(presetn),
        .clear(core_reset_r),
        .tick(wdt_tick)
    );

    // Monitor state, cause flags and software requests
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_monitor_enable <= 1'b1;
            monitor_select_r <= 1'b1;
            power_on_reset_flag <= 1'b0;
            ram_invalid_r <= 1'b1;
            warn_ie_r <= 1'b0;
            flash_err_flag_r <= 1'b0;
            sw_rst_req_r <= 1'b0;
            flash_rst_req_r <= 1'b0;
            warn_irq_r <= 1'b0;
        end else begin
            warn_irq_r <= warn_ie_r & ~supply_early_warning_flag;
            if (state_r != `RSMC_RST_RUN) begin
                sw_rst_req_r <= 1'b0;
                flash_rst_req_r <= 1'b0;
                if (state_r == `RSMC_RST_IDLE || pf_fault) begin
                    supply_monitor_enable <= 1'b1;
                    monitor_select_r <= 1'b1;
                    power_on_reset_flag <= 1'b1;
                    ram_invalid_r <= 1'b1;
                    flash_err_flag_r <= 1'b0;
                end else if (state_r == `RSMC_RST_HOLD && soft_cause) begin
                    power_on_reset_flag <= 1'b0;
                end
            end else begin
                ram_invalid_r <= 1'b0;
                if (flash_write_req && !supply_monitor_enable) begin
                    flash_rst_req_r <= 1'b1;
                    flash_err_flag_r <= 1'b1;
                end
                if (wr_en && addr_hit(paddr, `RSMC_ADDR_MON_CTRL)
                    && pstrb[0]) begin
                    supply_monitor_enable <=
                        pwdata[`RSMC_BIT_MON_EN];
                    warn_ie_r <= pwdata[`RSMC_BIT_WARN_IE];
                end
                if (wr_en && addr_hit(paddr, `RSMC_ADDR_RST_SRC)
                    && pstrb[0]) begin
                    // Writing zero deselects the monitor as a reset cause
                    monitor_select_r <=
                        pwdata[`RSMC_BIT_POR_FLAG];
                    sw_rst_req_r <= pwdata[`RSMC_BIT_SW_RST];
                end
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata_r <= 32'h0000_0000;
            if (addr_hit(paddr, `RSMC_ADDR_MON_CTRL)) begin
                rdata_r[`RSMC_BIT_MON_EN] <= supply_monitor_enable;
                rdata_r[`RSMC_BIT_SUPPLY_OK] <= supply_above_reset;
                rdata_r[`RSMC_BIT_WARN_OK] <=
                    supply_early_warning_flag;
                rdata_r[`RSMC_BIT_WARN_IE] <= warn_ie_r;
            end else if (addr_hit(paddr, `RSMC_ADDR_RST_SRC)) begin
                rdata_r[`RSMC_BIT_POR_FLAG] <= power_on_reset_flag;
                rdata_r[`RSMC_BIT_FLASH_ERR] <= flash_err_flag_r;
            end else if (addr_hit(paddr, `RSMC_ADDR_STATUS)) begin
                rdata_r[`RSMC_BIT_IN_RESET] <= core_reset_r;
            end else if (addr_hit(paddr, `RSMC_ADDR_FLASH)) begin
                rdata_r[`RSMC_BIT_FLASH_OP] <= monitor_select_r;
            end
        end
    end
endmodule // rsmc_top

// *** verif/rsmc_props.sv ***
// Concurrent checks on the reset and supply monitor controller ports
`timescale 1ns/10ps
module rsmc_props #(
    parameter [23:0] POR_DELAY_CYC = 24'h4_93e0
) (
    input wire pclk,
    input wire presetn,
    input wire power_on_ok,
    input wire supply_above_reset,
    input wire supply_above_warn,
    input wire core_reset_r,
    input wire reset_pin_out_r,
    input wire reset_pin_oe_r,
    input wire [7:0] port_latch_r,
    input wire port_open_drain_r,
    input wire port_pullup_en_r,
    input wire [15:0] pc_r,
    input wire wdt_enable_r,
    input wire wdt_tick,
    input wire warn_irq_r
);
    reg por_r;
    reg [23:0] cnt_r;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Cycles spent in reset with the power-on comparator high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_r <= 1'b1;
            cnt_r <= 24'h00_0000;
        end else begin
            por_r <= por_r & core_reset_r;
            cnt_r <= core_reset_r ? cnt_r + {23'h0, power_on_ok} : 24'h0;
        end
    end
    sequence s_supply_back;
        core_reset_r && !por_r && $rose(supply_above_reset);
    endsequence
    property p_tick_gap;
        disable iff (!presetn || core_reset_r)
        wdt_tick |=> (!wdt_tick)[*8] ##1 (!wdt_tick)[*3] ##1 wdt_tick;
    endproperty
    a_reset_state_outs: assert property (
        core_reset_r |-> port_latch_r == 8'hff && port_open_drain_r
        && pc_r == 16'h0000) else $error("reset state outputs wrong");
    a_pullup_always: assert property (
        port_pullup_en_r) else $error("pullups off");
    a_pin_drive_low: assert property (
        reset_pin_oe_r |-> !reset_pin_out_r) else $error("pin driven high");
    a_pin_free_run: assert property (
        !core_reset_r && !$past(core_reset_r) |-> !reset_pin_oe_r)
        else $error("pin driven while running");
    a_wdt_on_exit: assert property (
        $fell(core_reset_r) |-> ##[0:1] wdt_enable_r)
        else $error("watchdog not enabled on exit");
    a_wdt_tick_gap: assert property (p_tick_gap)
        else $error("watchdog tick period wrong");
    a_warn_irq_cause: assert property (
        warn_irq_r |-> !$past(supply_above_warn))
        else $error("warning irq without low supply");
    a_por_delay_len: assert property (
        $fell(core_reset_r) && por_r |-> cnt_r >= POR_DELAY_CYC)
        else $error("power-on release too early");
    a_fault_release: assert property (
        s_supply_back |-> ##[1:12] !core_reset_r)
        else $error("monitor reset release late");
endmodule // rsmc_props

bind rsmc_top rsmc_props #(.POR_DELAY_CYC(POR_DELAY_CYC)) rsmc_props_i (
    .pclk, .presetn, .power_on_ok, .supply_above_reset, .supply_above_warn,
    .core_reset_r, .reset_pin_out_r, .reset_pin_oe_r, .port_latch_r,
    .port_open_drain_r, .port_pullup_en_r, .pc_r, .wdt_enable_r, .wdt_tick,
    .warn_irq_r);

// *** verif/rsmc_far_side.sv ***
// Far side model: reset pin with board pull-up and the core's first fetch
`timescale 1ns/10ps
module rsmc_far_side (
    input wire pclk,
    input wire pin_out,
    input wire pin_oe,
    input wire core_reset,
    input wire [15:0] pc,
    output wire pin_level,
    output reg [15:0] fetch_addr_r
);
    // A released pin floats up, so a stale low never reads as driven
    assign pin_level = pin_oe ? pin_out : 1'b1;
    always @(posedge pclk) begin
        if (core_reset) begin
            fetch_addr_r <= pc;
        end
    end
endmodule // rsmc_far_side

// *** verif/tb_top.sv ***
// Self-checking testbench for the reset and supply monitor controller
`timescale 1ns/10ps
`include "rsmc_consts.vh"
module tb_top;
    localparam [23:0] POR_CYC = 24'h00_0028;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    reg pwrite = 1'b0, power_on_ok = 1'b0, sleep_mode = 1'b0;
    reg supply_above_reset = 1'b1, supply_above_warn = 1'b1;
    reg flash_write_req = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000, rd;
    wire [31:0] prdata;
    wire [15:0] pc_r, fetch_addr_r;
    wire [7:0] port_latch_r;
    wire pready, pslverr, core_reset_r, reset_pin_out_r, reset_pin_oe_r;
    wire port_open_drain_r, port_pullup_en_r, sp_reset_r, sfr_init_r;
    wire irq_timer_disable_r, internal_osc_sel_r, wdt_enable_r, wdt_tick;
    wire ram_invalid_r, warn_irq_r, pin_level;
    integer fail_count = 0, compares = 0, n;
    rsmc_top #(.POR_DELAY_CYC(POR_CYC)) rsmc_top_i (.pclk, .presetn, .paddr,
        .psel, .penable, .pwrite, .pwdata, .pstrb(4'hf), .prdata, .pready,
        .pslverr, .power_on_ok, .supply_above_reset, .supply_above_warn,
        .sleep_mode, .flash_write_req, .core_reset_r, .reset_pin_out_r,
        .reset_pin_oe_r, .port_latch_r, .port_open_drain_r, .port_pullup_en_r,
        .sp_reset_r, .sfr_init_r, .irq_timer_disable_r, .pc_r,
        .internal_osc_sel_r, .wdt_enable_r, .wdt_tick, .ram_invalid_r,
        .warn_irq_r);
    rsmc_far_side rsmc_far_side_i (.pclk, .pin_out(reset_pin_out_r),
        .pin_oe(reset_pin_oe_r), .core_reset(core_reset_r), .pc(pc_r),
        .pin_level, .fetch_addr_r);
    always #5 pclk = ~pclk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            // Only the watchdog ends a stalled access
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wait_rst(input v);
        begin
            n = 0;
            while (core_reset_r !== v && n < 200) begin
                @(posedge pclk);
                n = n + 1;
            end
            if (core_reset_r !== v) begin
                fail_count = fail_count + 1;
            end
        end
    endtask
    task t_power_on;
        begin
            repeat (20) @(posedge pclk);
            presetn <= 1'b1;
            repeat (5) @(posedge pclk);
            chk({core_reset_r, pin_level, port_latch_r}, 10'h2ff);
            chk({sp_reset_r, sfr_init_r, irq_timer_disable_r}, 3'h7);
            power_on_ok <= 1'b1;
            wait_rst(1'b0);
            chk(n >= POR_CYC - 1, 1'b1);
            @(posedge pclk);
            chk({wdt_enable_r, pin_level, fetch_addr_r}, 18'h3_0000);
            chk({internal_osc_sel_r, pready, pslverr}, 3'h6);
            n = 0;
            repeat (24) @(posedge pclk) n = n + wdt_tick;
            chk(n, 2);
        end
    endtask
    task t_regs;
        begin
            apb(1'b0, `RSMC_ADDR_MON_CTRL, 32'h0);
            chk(rd, 32'h0000_00e0);
            apb(1'b0, `RSMC_ADDR_RST_SRC, 32'h0);
            chk(rd[1], 1'b1);
            apb(1'b0, `RSMC_ADDR_FLASH, 32'h0);
            chk(rd[0], 1'b1);
            apb(1'b0, 12'h010, 32'h0);
            chk(rd, 32'h0);
            supply_above_warn <= 1'b0;
            apb(1'b1, `RSMC_ADDR_MON_CTRL, 32'h0000_0081);
            apb(1'b0, `RSMC_ADDR_MON_CTRL, 32'h0);
            chk({rd[7:5], warn_irq_r}, 4'hd);
            supply_above_warn <= 1'b1;
            repeat (3) @(posedge pclk);
            chk(warn_irq_r, 1'b0);
        end
    endtask
    task t_soft_and_flash;
        begin
            apb(1'b1, `RSMC_ADDR_MON_CTRL, 32'h0);
            apb(1'b1, `RSMC_ADDR_RST_SRC, 32'h0);
            apb(1'b1, `RSMC_ADDR_RST_SRC, 32'h0000_0010);
            wait_rst(1'b1);
            chk(pin_level, 1'b1);
            apb(1'b0, `RSMC_ADDR_STATUS, 32'h0);
            chk(rd[0], 1'b1);
            wait_rst(1'b0);
            apb(1'b0, `RSMC_ADDR_MON_CTRL, 32'h0);
            chk(rd[7], 1'b0);
            apb(1'b0, `RSMC_ADDR_RST_SRC, 32'h0);
            chk(rd[1], 1'b0);
            flash_write_req <= 1'b1;
            @(posedge pclk);
            flash_write_req <= 1'b0;
            wait_rst(1'b1);
            chk(n < 8, 1'b1);
            wait_rst(1'b0);
            apb(1'b0, `RSMC_ADDR_FLASH, 32'h0);
            chk(rd[0], 1'b0);
            apb(1'b0, `RSMC_ADDR_RST_SRC, 32'h0);
            chk({rd[6], rd[1]}, 2'h2);
            // Enable before select, and keep the flag bit set on each write
            apb(1'b1, `RSMC_ADDR_MON_CTRL, 32'h0000_0080);
            apb(1'b1, `RSMC_ADDR_RST_SRC, 32'h0000_0002);
        end
    endtask
    task t_sleep_and_fault;
        begin
            sleep_mode <= 1'b1;
            supply_above_reset <= 1'b0;
            repeat (20) @(posedge pclk);
            chk(core_reset_r, 1'b0);
            supply_above_reset <= 1'b1;
            sleep_mode <= 1'b0;
            apb(1'b0, `RSMC_ADDR_FLASH, 32'h0);
            chk(rd[0], 1'b1);
            supply_above_reset <= 1'b0;
            repeat (30) @(posedge pclk);
            chk({core_reset_r, pin_level, ram_invalid_r}, 3'h5);
            supply_above_reset <= 1'b1;
            wait_rst(1'b0);
            chk(n < POR_CYC, 1'b1);
            apb(1'b0, `RSMC_ADDR_RST_SRC, 32'h0);
            chk(rd[1], 1'b1);
        end
    endtask
    task t_power_drop;
        begin
            apb(1'b1, `RSMC_ADDR_MON_CTRL, 32'h0);
            power_on_ok <= 1'b0;
            @(posedge pclk);
            power_on_ok <= 1'b1;
            wait_rst(1'b1);
            chk(pin_level, 1'b0);
            wait_rst(1'b0);
            chk(n >= POR_CYC - 1, 1'b1);
            apb(1'b0, `RSMC_ADDR_MON_CTRL, 32'h0);
            chk(rd[7], 1'b1);
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares=%0d fail_count=%0d", compares, fail_count);
            if (fail_count == 0 && compares > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    initial begin
        t_power_on;
        t_regs;
        t_soft_and_flash;
        t_sleep_and_fault;
        t_power_drop;
        tally_and_finish;
    end
    initial begin
        #100000;
        fail_count = fail_count + 1;
        tally_and_finish;
    end
endmodule // tb_top
